/* File: rtl/link_event_defs.vh */
`ifndef LINK_EVENT_DEFS_VH
`define LINK_EVENT_DEFS_VH

// register byte offsets on the host register port
`define OFS_UNIQUE_ID_UPPER     8'h24
`define OFS_UNIQUE_ID_LOWER     8'h28
`define OFS_EVENT_FLAGS_SET     8'h80
`define OFS_EVENT_FLAGS_CLEAR   8'h84
`define OFS_EVENT_ENABLES_SET   8'h88
`define OFS_EVENT_ENABLES_CLEAR 8'h8c
`define OFS_CONTEXT_RUN_SET     8'h90
`define OFS_CONTEXT_RUN_CLEAR   8'h94
`define OFS_BRIDGE_CONTROL      8'h98

// event bit positions, shared by the flag and enable registers
`define BIT_REQUEST_SEND_DONE        0
`define BIT_RESPONSE_SEND_DONE       1
`define BIT_REQUEST_BUFFER_FILLED    2
`define BIT_RESPONSE_BUFFER_FILLED   3
`define BIT_REQUEST_PACKET_ARRIVED   4
`define BIT_RESPONSE_PACKET_ARRIVED  5
`define BIT_TIMED_SEND_SUMMARY       6
`define BIT_TIMED_RECEIVE_SUMMARY    7
`define BIT_POSTED_STORE_FAULT       8
`define BIT_ATOMIC_REPLY_FAULT       9
`define BIT_NODE_CENSUS_DONE         16
`define BIT_LINK_REINIT_SEEN         17
`define BIT_PHY_EVENT                19
`define BIT_FRAME_TICK_SYNC          20
`define BIT_FRAME_COUNTER_WRAP       21
`define BIT_FRAME_START_MISSED       22
`define BIT_FRAME_TIME_MISMATCH      23
`define BIT_FATAL_FAULT              24
`define BIT_FRAME_OVERRUN            25
`define BIT_PHY_REG_REPLY_ARRIVED    26
`define BIT_GLOBAL_IRQ_GATE          31

// implemented bits; all others are reserved and read zero
`define EVENT_IMPL_MASK   32'h07fb_03ff
`define ENABLE_IMPL_MASK  32'h87fb_03ff

// reset values
`define EVENT_FLAGS_RESET   32'h0000_0000
`define EVENT_ENABLES_RESET 32'h0000_0000
`define CONTEXT_RUN_RESET   4'h0
`define UNIQUE_ID_RESET     32'h0000_0000

// unique identifier upper word fields
`define MAKER_CODE_MSB      31
`define MAKER_CODE_LSB      8
`define PART_CODE_UPPER_MSB 7
`define PART_CODE_UPPER_LSB 0

// descriptor interrupt select encodings
`define ISEL_NEVER    2'b00
`define ISEL_ON_FAIL  2'b01
`define ISEL_ALWAYS   2'b11

// context indexes
`define CTX_REQUEST_SEND     0
`define CTX_RESPONSE_SEND    1
`define CTX_REQUEST_RECEIVE  2
`define CTX_RESPONSE_RECEIVE 3
`define CTX_COUNT            4

`endif

/* File: rtl/dma_completion_qualify.v */
`timescale 1ns/1ns
`include "link_event_defs.vh"

// decides, for one dma context, whether a finished descriptor raises its
// completion event and whether its status is written back to host memory
module dma_completion_qualify #(
    parameter IS_SEND = 1                // 1 for a send context, 0 for receive
) (
    input  wire       i_ref_clk,
    input  wire       i_reset,
    input  wire       i_run,             // context has been started by software
    input  wire       i_desc_done,       // final descriptor finished, one cycle
    input  wire       i_desc_abort,      // transfer aborted, one cycle
    input  wire [1:0] i_int_select,      // descriptor interrupt select field
    input  wire       i_ack_good,        // send got ack_complete or ack_pending
    input  wire       i_status_update,   // descriptor asks for status write-back
    output reg        o_event,           // completion event pulse
    output reg        o_writeback        // status write-back request pulse
);

////////////////////////////////////////////////////////////////////////////////
// qualification

wire finished;                           // any end of transfer while running
wire raise;                              // completion event condition

// an abort is treated like an unacknowledged send, so it can still interrupt
assign finished = i_run & (i_desc_done | i_desc_abort);

// send: always on 11b, or on 01b when the packet was not acknowledged
// receive: only 11b raises the buffer-filled event
assign raise = finished &
               ((i_int_select == `ISEL_ALWAYS) |
                ((IS_SEND != 0) && (i_int_select == `ISEL_ON_FAIL) &&
                 (!i_ack_good || i_desc_abort)));

// outputs are registered, one cycle after the completion strobe
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_event     <= 1'b0;
        o_writeback <= 1'b0;
    end else begin
        o_event     <= raise;
        o_writeback <= finished & i_status_update;
    end
end

endmodule

/* File: rtl/link_event_interrupt_unit.v */
`timescale 1ns/1ns
`include "link_event_defs.vh"

// What this block does
// - event flags latch until software clears them
// - enable bits gate flags onto interrupt line
// - clear register write drops selected flags
// - send completion on select 11b or unacked 01b
// - request and response sends have separate bits
// - packet arrival raises packet-arrived event
// - receive buffer done with 11b raises filled
// - contexts report descriptor completion, conditional status writeback
// - completion or abort may both interrupt
// - unit events such as node census done
// - timed per-context events summarised at 6, 7
// - flags and enables share one bit layout
// - global gate at enable bit 31 only
// - unique identifier two words, maker and part
// - bridge mode executes bus reads/writes on memory
// - contexts start only when software commands
// - unique identifier words accept first write only
module link_event_interrupt_unit #(
    parameter TIMED_CONTEXTS = 8         // isochronous contexts per direction
) (
    input  wire                      i_ref_clk,
    input  wire                      i_reset,
    // host register port
    input  wire [7:0]                i_reg_addr,
    input  wire                      i_reg_wr,
    input  wire                      i_reg_rd,
    input  wire [31:0]               i_reg_wdata,
    output reg  [31:0]               o_reg_rdata,
    output reg                       o_reg_rvalid,
    // dma context completion reporting, index by context
    input  wire [3:0]                i_desc_done,
    input  wire [3:0]                i_desc_abort,
    input  wire [7:0]                i_int_select,
    input  wire [1:0]                i_send_ack_good,
    input  wire [3:0]                i_status_update,
    output wire [3:0]                o_status_writeback,
    output wire [3:0]                o_context_run,
    // receive packet arrivals
    input  wire                      i_request_packet_arrived,
    input  wire                      i_response_packet_arrived,
    // timed contexts
    input  wire [TIMED_CONTEXTS-1:0] i_timed_send_events,
    input  wire [TIMED_CONTEXTS-1:0] i_timed_receive_events,
    // other unit events, one-cycle pulses
    input  wire                      i_posted_store_fault,
    input  wire                      i_atomic_reply_fault,
    input  wire                      i_node_census_done,
    input  wire                      i_link_reinit_seen,
    input  wire                      i_phy_event,
    input  wire                      i_frame_tick_sync,
    input  wire                      i_frame_counter_wrap,
    input  wire                      i_frame_start_missed,
    input  wire                      i_frame_time_mismatch,
    input  wire                      i_fatal_fault,
    input  wire                      i_frame_overrun,
    input  wire                      i_phy_reg_reply_arrived,
    // bridge mode
    input  wire                      i_bridge_req,
    input  wire                      i_bridge_req_write,
    output wire                      o_bridge_enable,
    output reg                       o_bridge_mem_rd,
    output reg                       o_bridge_mem_wr,
    output reg                       o_bridge_reject,
    // identifier and interrupt
    output wire [31:0]               o_unique_id_upper,
    output wire [31:0]               o_unique_id_lower,
    output reg                       o_irq
);

////////////////////////////////////////////////////////////////////////////////
// state

reg  [31:0] event_flags;                 // latched interrupt events
reg  [31:0] event_enables;               // per-event enables plus global gate
reg  [3:0]  context_run;                 // software started contexts
reg         bridge_enable;               // bridge mode switched on
reg  [31:0] unique_id_upper;             // maker code and upper part code
reg  [31:0] unique_id_lower;             // lower part code
reg         upper_locked;                // upper word already written
reg         lower_locked;                // lower word already written

wire [3:0]  ctx_event;                   // qualified completion per context
wire [31:0] hw_events;                   // this cycle's hardware events
wire [31:0] gated;                       // flags passing their enables

// register port decode
wire wr_flags_set     = i_reg_wr & (i_reg_addr == `OFS_EVENT_FLAGS_SET);
wire wr_flags_clear   = i_reg_wr & (i_reg_addr == `OFS_EVENT_FLAGS_CLEAR);
wire wr_enables_set   = i_reg_wr & (i_reg_addr == `OFS_EVENT_ENABLES_SET);
wire wr_enables_clear = i_reg_wr & (i_reg_addr == `OFS_EVENT_ENABLES_CLEAR);
wire wr_run_set       = i_reg_wr & (i_reg_addr == `OFS_CONTEXT_RUN_SET);
wire wr_run_clear     = i_reg_wr & (i_reg_addr == `OFS_CONTEXT_RUN_CLEAR);
wire wr_bridge        = i_reg_wr & (i_reg_addr == `OFS_BRIDGE_CONTROL);
wire wr_id_upper      = i_reg_wr & (i_reg_addr == `OFS_UNIQUE_ID_UPPER);
wire wr_id_lower      = i_reg_wr & (i_reg_addr == `OFS_UNIQUE_ID_LOWER);

////////////////////////////////////////////////////////////////////////////////
// per-context completion qualification

genvar c;
generate
    for (c = 0; c < `CTX_COUNT; c = c + 1) begin : g_ctx
        // the two send contexts use the ack check, receive ones do not
        dma_completion_qualify #(
            .IS_SEND ((c < 2) ? 1 : 0)
        ) u_qualify (
            .i_ref_clk       (i_ref_clk),
            .i_reset         (i_reset),
            .i_run           (context_run[c]),
            .i_desc_done     (i_desc_done[c]),
            .i_desc_abort    (i_desc_abort[c]),
            .i_int_select    (i_int_select[2*c+1:2*c]),
            .i_ack_good      ((c < 2) ? i_send_ack_good[c & 1] : 1'b1),
            .i_status_update (i_status_update[c]),
            .o_event         (ctx_event[c]),
            .o_writeback     (o_status_writeback[c])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// event vector in the shared layout

// every unassigned position stays zero, so reserved bits never latch
assign hw_events = {
    5'h00,                                                  // 31..27
    i_phy_reg_reply_arrived,                                // 26
    i_frame_overrun,                                        // 25
    i_fatal_fault,                                          // 24
    i_frame_time_mismatch,                                  // 23
    i_frame_start_missed,                                   // 22
    i_frame_counter_wrap,                                   // 21
    i_frame_tick_sync,                                      // 20
    i_phy_event,                                            // 19
    1'b0,                                                   // 18
    i_link_reinit_seen,                                     // 17
    i_node_census_done,                                     // 16
    6'h00,                                                  // 15..10
    i_atomic_reply_fault,                                   // 9
    i_posted_store_fault,                                   // 8
    |i_timed_receive_events,                                // 7
    |i_timed_send_events,                                   // 6
    i_response_packet_arrived,                              // 5
    i_request_packet_arrived,                               // 4
    ctx_event[`CTX_RESPONSE_RECEIVE],                       // 3
    ctx_event[`CTX_REQUEST_RECEIVE],                        // 2
    ctx_event[`CTX_RESPONSE_SEND],                          // 1
    ctx_event[`CTX_REQUEST_SEND]                            // 0
};

////////////////////////////////////////////////////////////////////////////////
// event flags

// set beats clear: an event in the clearing cycle is kept, so software
// never misses it even when it races its own acknowledge
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        event_flags <= `EVENT_FLAGS_RESET;
    end else begin
        event_flags <= ((event_flags
                        & ~(wr_flags_clear ? i_reg_wdata : 32'h0000_0000))
                        | (wr_flags_set ? i_reg_wdata : 32'h0000_0000)
                        | hw_events)
                       & `EVENT_IMPL_MASK;
    end
end

////////////////////////////////////////////////////////////////////////////////
// event enables

// global gate lives only here, at bit 31
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        event_enables <= `EVENT_ENABLES_RESET;
    end else if (wr_enables_set) begin
        event_enables <= (event_enables | i_reg_wdata) & `ENABLE_IMPL_MASK;
    end else if (wr_enables_clear) begin
        event_enables <= event_enables & ~i_reg_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt line

assign gated = event_flags & event_enables;

// registered so the line is glitch free; it follows the flags by one cycle
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_irq <= 1'b0;
    end else begin
        o_irq <= event_enables[`BIT_GLOBAL_IRQ_GATE] & (|gated);
    end
end

////////////////////////////////////////////////////////////////////////////////
// context run control

// a context only reports completions after software has started it
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        context_run <= `CONTEXT_RUN_RESET;
    end else if (wr_run_set) begin
        context_run <= context_run | i_reg_wdata[3:0];
    end else if (wr_run_clear) begin
        context_run <= context_run & ~i_reg_wdata[3:0];
    end
end

assign o_context_run = context_run;

////////////////////////////////////////////////////////////////////////////////
// bridge mode

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        bridge_enable <= 1'b0;
    end else if (wr_bridge) begin
        bridge_enable <= i_reg_wdata[0];
    end
end

assign o_bridge_enable = bridge_enable;

// incoming bus transactions turn into host memory accesses while enabled;
// otherwise they are rejected so the link can answer with an error
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_bridge_mem_rd <= 1'b0;
        o_bridge_mem_wr <= 1'b0;
        o_bridge_reject <= 1'b0;
    end else begin
        o_bridge_mem_rd <= i_bridge_req & bridge_enable & ~i_bridge_req_write;
        o_bridge_mem_wr <= i_bridge_req & bridge_enable & i_bridge_req_write;
        o_bridge_reject <= i_bridge_req & ~bridge_enable;
    end
end

////////////////////////////////////////////////////////////////////////////////
// unique identifier, write once per word

// later writes are silently dropped; only reset reopens the words
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        unique_id_upper <= `UNIQUE_ID_RESET;
        unique_id_lower <= `UNIQUE_ID_RESET;
        upper_locked    <= 1'b0;
        lower_locked    <= 1'b0;
    end else begin
        if (wr_id_upper && !upper_locked) begin
            unique_id_upper <= i_reg_wdata;
            upper_locked    <= 1'b1;
        end
        if (wr_id_lower && !lower_locked) begin
            unique_id_lower <= i_reg_wdata;
            lower_locked    <= 1'b1;
        end
    end
end

assign o_unique_id_upper = unique_id_upper;
assign o_unique_id_lower = unique_id_lower;

////////////////////////////////////////////////////////////////////////////////
// register read

reg [31:0] next_rdata;                   // decoded read value

// both the set and clear offsets read back the same register
always @* begin
    next_rdata = 32'h0000_0000;
    case (i_reg_addr)
        `OFS_EVENT_FLAGS_SET,
        `OFS_EVENT_FLAGS_CLEAR: begin
            next_rdata = event_flags;
        end
        `OFS_EVENT_ENABLES_SET,
        `OFS_EVENT_ENABLES_CLEAR: begin
            next_rdata = event_enables;
        end
        `OFS_CONTEXT_RUN_SET,
        `OFS_CONTEXT_RUN_CLEAR: begin
            next_rdata = {28'h0000000, context_run};
        end
        `OFS_BRIDGE_CONTROL: begin
            next_rdata = {31'h00000000, bridge_enable};
        end
        `OFS_UNIQUE_ID_UPPER: begin
            next_rdata = unique_id_upper;
        end
        `OFS_UNIQUE_ID_LOWER: begin
            next_rdata = unique_id_lower;
        end
        default: begin
            next_rdata = 32'h0000_0000; // unmapped reads zero
        end
    endcase
end

// read data is held until the next read
always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_reg_rdata  <= 32'h0000_0000;
        o_reg_rvalid <= 1'b0;
    end else begin
        o_reg_rvalid <= i_reg_rd;
        if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end
    end
end

endmodule

/* File: bench/host_software_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// host software model: one strobe per access
module host_software_model (
    input  wire        i_ref_clk,
    input  wire [31:0] i_reg_rdata,
    input  wire        i_reg_rvalid,
    output reg  [7:0]  o_reg_addr,
    output reg         o_reg_wr,
    output reg         o_reg_rd,
    output reg  [31:0] o_reg_wdata
);
    // idle port at time zero
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_wdata = 32'h0000_0000;
    end
    // clears and context starts only ever go out through this write
    task reg_write(input [7:0] addr, input [31:0] data);
        @(posedge i_ref_clk);
        #2;
        o_reg_addr  = addr;
        o_reg_wdata = data;
        o_reg_wr    = 1'b1;
        @(posedge i_ref_clk);
        #2;
        o_reg_wr    = 1'b0;
        o_reg_wdata = ~data; // stale data must not look valid
    endtask
    // answer taken one edge after the strobe
    task reg_read(input [7:0] addr, output [31:0] data, output valid);
        @(posedge i_ref_clk);
        #2;
        o_reg_addr = addr;
        o_reg_rd   = 1'b1;
        @(posedge i_ref_clk);
        #2;
        o_reg_rd   = 1'b0;
        data       = i_reg_rdata;
        valid      = i_reg_rvalid;
    endtask
endmodule

/* File: bench/link_event_interrupt_unit_monitor.sv */
`timescale 1ns/1ns
`include "link_event_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// port-level checker
module link_event_interrupt_unit_monitor (
    input wire        i_ref_clk,
    input wire        i_reset,
    input wire [7:0]  i_reg_addr,
    input wire        i_reg_wr,
    input wire        i_reg_rd,
    input wire [31:0] i_reg_wdata,
    input wire [31:0] o_reg_rdata,
    input wire        o_reg_rvalid,
    input wire [3:0]  i_desc_done,
    input wire [3:0]  i_desc_abort,
    input wire [3:0]  i_status_update,
    input wire [3:0]  o_status_writeback,
    input wire [3:0]  o_context_run,
    input wire        i_bridge_req,
    input wire        i_bridge_req_write,
    input wire        o_bridge_enable,
    input wire        o_bridge_mem_rd,
    input wire        o_bridge_mem_wr,
    input wire        o_bridge_reject,
    input wire [31:0] o_unique_id_upper,
    input wire        o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // gate dropped, not set again
    sequence gate_cleared;
        (i_reg_wr && i_reg_addr == `OFS_EVENT_ENABLES_CLEAR && i_reg_wdata[31])
        ##1 !(i_reg_wr && i_reg_addr == `OFS_EVENT_ENABLES_SET);
    endsequence
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe without answer");
    answer_only_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("stray answer");
    reserved_zero_a: assert property (i_reg_rd && i_reg_addr == `OFS_EVENT_FLAGS_SET
        |=> (o_reg_rdata & ~`EVENT_IMPL_MASK) == 32'h0)
        else $error("reserved bit set");
    gate_off_a: assert property (gate_cleared |=> !o_irq)
        else $error("irq with gate off");
    wb_running_a: assert property (o_context_run[0] && i_status_update[0]
        && (i_desc_done[0] || i_desc_abort[0]) |=> o_status_writeback[0])
        else $error("write-back missing");
    wb_cause_a: assert property (!(i_desc_done[0] || i_desc_abort[0])
        |=> !o_status_writeback[0])
        else $error("stray write-back");
    id_lock_a: assert property (o_unique_id_upper != 32'h0
        |=> $stable(o_unique_id_upper))
        else $error("id changed after lock");
    bridge_off_a: assert property (i_bridge_req && !o_bridge_enable
        |=> o_bridge_reject && !o_bridge_mem_rd && !o_bridge_mem_wr)
        else $error("bridge not rejected");
    bridge_on_a: assert property (i_bridge_req && o_bridge_enable
        |=> o_bridge_mem_wr == $past(i_bridge_req_write)
        && o_bridge_mem_rd == !$past(i_bridge_req_write))
        else $error("bridge wrong kind");
    cover property (o_irq);
    cover property (gate_cleared);
    cover property (i_bridge_req && o_bridge_enable);
endmodule
bind link_event_interrupt_unit link_event_interrupt_unit_monitor u_monitor (.*);

/* File: bench/link_event_interrupt_unit_tb_top.sv */
`timescale 1ns/1ns
`include "link_event_defs.vh"
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module link_event_interrupt_unit_tb_top;
    logic        i_ref_clk = 1'b0, i_reset = 1'b1;
    wire  [7:0]  i_reg_addr;
    wire         i_reg_wr, i_reg_rd, o_reg_rvalid, o_irq, o_bridge_enable;
    wire  [31:0] i_reg_wdata, o_reg_rdata, o_unique_id_upper, o_unique_id_lower;
    wire         o_bridge_mem_rd, o_bridge_mem_wr, o_bridge_reject;
    wire  [3:0]  o_status_writeback, o_context_run;
    logic [3:0]  i_desc_done = 4'h0, i_desc_abort = 4'h0, i_status_update = 4'h0;
    logic [7:0]  i_int_select = 8'h00;
    logic [1:0]  i_send_ack_good = 2'h0;
    logic        i_bridge_req = 1'b0, i_bridge_req_write = 1'b0;
    logic [31:0] unit_ev = 32'h0;  // unit events at flag positions
    logic [2:0]  tsel = 3'h0;      // timed context
    wire  [7:0]  i_timed_send_events = unit_ev[6] ? (8'h01 << tsel) : 8'h00;
    wire  [7:0]  i_timed_receive_events = unit_ev[7] ? (8'h01 << tsel) : 8'h00;
    wire         i_request_packet_arrived, i_response_packet_arrived;
    wire         i_posted_store_fault, i_atomic_reply_fault, i_node_census_done;
    wire         i_link_reinit_seen, i_phy_event, i_frame_tick_sync, i_frame_counter_wrap;
    wire         i_frame_start_missed, i_frame_time_mismatch, i_fatal_fault;
    wire         i_frame_overrun, i_phy_reg_reply_arrived;
    integer      seed, failures = 0, check_count = 0, i;
    logic [31:0] d, a;
    logic        v, e;
    assign {i_response_packet_arrived, i_request_packet_arrived} = unit_ev[5:4];
    assign {i_atomic_reply_fault, i_posted_store_fault} = unit_ev[9:8];
    assign {i_link_reinit_seen, i_node_census_done} = unit_ev[17:16];
    assign {i_phy_reg_reply_arrived, i_frame_overrun, i_fatal_fault, i_frame_time_mismatch,
            i_frame_start_missed, i_frame_counter_wrap, i_frame_tick_sync,
            i_phy_event} = unit_ev[26:19];
    link_event_interrupt_unit u_link_event_interrupt_unit (.*);
    host_software_model u_host_software_model (.i_ref_clk(i_ref_clk),
        .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid), .o_reg_addr(i_reg_addr),
        .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));
    ////////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    task wr(input [7:0] addr, input [31:0] data);
        u_host_software_model.reg_write(addr, data);
    endtask
    task rd(input [7:0] addr);
        u_host_software_model.reg_read(addr, d, v);
    endtask
    // unit events held exactly one cycle
    task pulse(input [31:0] ev);
        @(posedge i_ref_clk);
        #2;
        unit_ev = ev;
        @(posedge i_ref_clk);
        #2;
        unit_ev = 32'h0;
    endtask
    task bridge(input w);
        @(posedge i_ref_clk);
        #2;
        i_bridge_req = 1'b1;
        i_bridge_req_write = w;
        @(posedge i_ref_clk);
        #2;
        i_bridge_req = 1'b0;
    endtask
    // sends also fire on a failed ack
    function logic ctx_exp(input [1:0] c, input [1:0] isel, input ack, input ab);
        ctx_exp = (isel == 2'b11) || (c < 2 && isel == 2'b01 && (!ack || ab));
    endfunction
    task end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, about a hundred times the test length
    initial begin
        #2000000;
        failures++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 4013;
        repeat (6) @(posedge i_ref_clk);
        #2;
        i_reset = 1'b0;
        rd(`OFS_EVENT_FLAGS_SET);
        `CHECK({v, d}, 33'h1_0000_0000)
        rd(`OFS_EVENT_ENABLES_SET);
        `CHECK(d, 32'h0)
        rd(8'h00); // unmapped place reads zero
        `CHECK(d, 32'h0)
        $display("test reset done");
        // every unit event latches alone and clears alone
        for (i = 4; i < 27; i++) if (`EVENT_IMPL_MASK >> i & 1) begin
            tsel = $random(seed);
            pulse(32'h1 << i);
            rd(`OFS_EVENT_FLAGS_SET);
            `CHECK(d, 32'h1 << i)
            wr(`OFS_EVENT_FLAGS_CLEAR, 32'h1 << i);
            rd(`OFS_EVENT_FLAGS_SET);
            `CHECK(d, 32'h0)
        end
        $display("test unit events done");
        a = $random(seed);
        wr(`OFS_EVENT_FLAGS_SET, a);
        wr(`OFS_EVENT_FLAGS_SET, 32'h0);
        rd(`OFS_EVENT_FLAGS_SET);
        `CHECK(d, a & `EVENT_IMPL_MASK)
        wr(`OFS_EVENT_FLAGS_CLEAR, 32'hffff_ffff);
        wr(`OFS_EVENT_ENABLES_SET, 32'hffff_ffff);
        rd(`OFS_EVENT_ENABLES_SET);
        `CHECK(d, `ENABLE_IMPL_MASK)
        wr(`OFS_EVENT_ENABLES_CLEAR, 32'hffff_ffff);
        // enabled flag alone, then gated
        wr(`OFS_EVENT_ENABLES_SET, 32'h0001_0000);
        pulse(32'h0001_0000);
        repeat (2) @(posedge i_ref_clk);
        `CHECK(o_irq, 1'b0)
        wr(`OFS_EVENT_ENABLES_SET, 32'h8000_0000);
        repeat (2) @(posedge i_ref_clk);
        `CHECK(o_irq, 1'b1)
        wr(`OFS_EVENT_FLAGS_CLEAR, 32'h0001_0000);
        repeat (2) @(posedge i_ref_clk);
        `CHECK(o_irq, 1'b0)
        wr(`OFS_EVENT_ENABLES_CLEAR, 32'h8000_0000);
        $display("test interrupt line done");
        // stopped contexts ignored, then every select and ack case
        for (i = 0; i < 36; i++) begin
            if (i == 4) wr(`OFS_CONTEXT_RUN_SET, 32'hf);
            if (i == 4) `CHECK(o_context_run, 4'hf)
            e = $random(seed);
            @(posedge i_ref_clk);
            #2;
            i_int_select = (i < 4 ? 2'b11 : i[3:2]) << (2 * i[1:0]);
            i_send_ack_good = {2{i[4]}};
            i_status_update = $random(seed);
            if (e) i_desc_abort = 4'h1 << i[1:0];
            else i_desc_done = 4'h1 << i[1:0];
            @(posedge i_ref_clk);
            #2;
            {i_desc_done, i_desc_abort} = 8'h00;
            rd(`OFS_EVENT_FLAGS_SET);
            if (i < 4) `CHECK(d, 32'h0)
            else `CHECK(d, ctx_exp(i[1:0], i[3:2], i[4], e) << i[1:0])
            wr(`OFS_EVENT_FLAGS_CLEAR, 32'hf);
        end
        $display("test contexts done");
        a = $random(seed) | 32'h1;
        wr(`OFS_UNIQUE_ID_UPPER, a);
        wr(`OFS_UNIQUE_ID_UPPER, ~a);
        wr(`OFS_UNIQUE_ID_LOWER, a);
        wr(`OFS_UNIQUE_ID_LOWER, ~a);
        rd(`OFS_UNIQUE_ID_UPPER);
        `CHECK(d, a)
        `CHECK(o_unique_id_lower, a)
        $display("test identifier done");
        bridge(1'b1);
        `CHECK(o_bridge_reject, 1'b1)
        wr(`OFS_BRIDGE_CONTROL, 32'h1);
        bridge(1'b1);
        `CHECK({o_bridge_mem_wr, o_bridge_mem_rd}, 2'b10)
        bridge(1'b0);
        `CHECK({o_bridge_mem_wr, o_bridge_mem_rd}, 2'b01)
        $display("test bridge done");
        end_sim;
    end
endmodule
